// [rtl/adcc_regs.svh]
// Purpose: Register offsets, bit positions and reset values for the converter control block
// Assumes: Byte wide register port with a 3-bit address
// Notes: Definitions only
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCC_OFF_RES_HIGH 3'h0
`define ADCC_OFF_RES_LOW 3'h1
`define ADCC_OFF_CTRL0 3'h2
`define ADCC_OFF_CTRL1 3'h3
`define ADCC_OFF_CTRL2 3'h4
`define ADCC_OFF_PINS_A 3'h5
`define ADCC_OFF_PINS_B 3'h6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCC_C0_START 7
`define ADCC_C0_BUSY 6
`define ADCC_C0_EN 5
`define ADCC_C0_JUST 4
`define ADCC_C0_CHAN_HI 2
`define ADCC_C0_CHAN_LO 0
`define ADCC_C1_SRC_HI 7
`define ADCC_C1_SRC_LO 5
`define ADCC_C1_DIV_HI 2
`define ADCC_C1_DIV_LO 0
`define ADCC_C2_AMP 7
`define ADCC_C2_BG 6
`define ADCC_C2_REF_HI 3
`define ADCC_C2_REF_LO 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_DIV 7'h00
`endif

// [rtl/adcc_pkg.sv]
// Purpose: Types and shared helpers for the converter control block
// Assumes: Eight-channel variant, 12-bit result
// Notes: Result packing is shared by the logic and its checks
package adcc_pkg;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } adcc_bus_type;
  // Where the converter input comes from
  typedef enum logic [1:0] {ADCC_SRC_PIN, ADCC_SRC_SUPPLY, ADCC_SRC_AMP} adcc_src_type;
  // Where the converter reference comes from
  typedef enum logic [1:0] {ADCC_REF_SUPPLY, ADCC_REF_PIN, ADCC_REF_BANDGAP} adcc_ref_type;
  typedef struct packed {
    adcc_src_type src;
    logic [2:0] chan;
    logic [1:0] scale;
    adcc_ref_type ref_src;
    logic [2:0] ref_mult;
  } adcc_route_type;
  // Answer from the analog core
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adcc_core_in_type;
  // Controls to the analog core
  typedef struct packed {
    logic enable;
    logic reset;
    logic start;
    logic tick;
    adcc_route_type route;
    logic amp_en;
    logic bg_en;
  } adcc_core_out_type;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcc_result_type;
  // Place a 12-bit result in the two bytes, unused bits zero
  function automatic adcc_result_type adcc_pack(input logic just, input logic [11:0] d);
    adcc_result_type r;
    if (just) begin
      r.high = {4'h0, d[11:8]};
      r.low = d[7:0];
    end else begin
      r.high = d[11:4];
      r.low = {d[3:0], 4'h0};
    end
    return r;
  endfunction
endpackage

// [rtl/adcc_divider.sv]
// Purpose: Converter clock tick from the system clock
// Assumes: Divide ratio is two to the power of the select
// Notes: Tick is one sys_clk cycle wide
`timescale 1ns/10ps
`include "adcc_regs.svh"
module adcc_divider import adcc_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Sync reset, high
  input wire logic run, // Converter enabled
  input wire logic [2:0] sel, // Divide select
  output logic tick // Converter clock tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } adcc_div_state_type;
  adcc_div_state_type s_reg, s_next; // Divider state
  // Terminal count for a ratio of 2**sel
  function automatic logic [6:0] div_limit(input logic [2:0] v);
    logic [7:0] p;
    p = 8'h01 << v;
    return 7'(p - 8'h01);
  endfunction
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = `ADCC_RST_DIV; // Idle while disabled saves toggling
    end else if (s_reg.cnt >= div_limit(sel)) begin
      s_next.cnt = `ADCC_RST_DIV;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = 7'(s_reg.cnt + 7'h01);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tick = s_reg.tick;
endmodule

// [rtl/adcc_route.sv]
// Purpose: Input and reference selection with priority
// Assumes: Select fields come from registers
// Notes: Pure decode, no state
`timescale 1ns/10ps
module adcc_route import adcc_pkg::*; (
  input wire logic [2:0] chan, // External channel select
  input wire logic [2:0] src_sel, // Internal source select
  input wire logic [3:0] ref_sel, // Reference select
  output adcc_route_type route // Decoded routing
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    route.chan = chan;
    route.scale = 2'(src_sel[1:0] - 2'h1);
    // Internal source overrides the pin
    case (src_sel)
      3'h1, 3'h2, 3'h3: route.src = ADCC_SRC_SUPPLY;
      3'h5, 3'h6, 3'h7: route.src = ADCC_SRC_AMP;
      default: begin
        route.src = ADCC_SRC_PIN;
        route.scale = 2'h0;
      end
    endcase
    route.ref_mult = ref_sel[2:0];
    // Bandgap codes win over the reference pin
    case (ref_sel)
      4'h1, 4'h2, 4'h3, 4'h4: route.ref_src = ADCC_REF_PIN;
      4'hA, 4'hB, 4'hC: route.ref_src = ADCC_REF_BANDGAP;
      default: begin
        route.ref_src = ADCC_REF_SUPPLY;
        route.ref_mult = 3'h1;
      end
    endcase
  end
endmodule

// [rtl/adcc_top.sv]
// Purpose: Control and result registers of a 12-bit converter
// Assumes: Eight-channel variant; analog core answers with a done pulse
// Notes: Byte register port, read data one cycle after the strobe
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "adcc_regs.svh"
module adcc_top import adcc_pkg::*; (
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic rst, // Sync reset, high
  input adcc_bus_type bus, // Register port request
  output logic [7:0] rdata, // Read data, one cycle late
  input adcc_core_in_type core_i, // Done and data from core
  output adcc_core_out_type core_o, // Controls to core
  output logic conv_irq, // Interrupt request pulse
  output logic [7:0] pa_analog, // Port A pins cut from I/O
  output logic [7:0] pb_analog, // Port B pins cut from I/O
  output logic [7:0] pa_pullup_off, // Port A pull-ups removed
  output logic [7:0] pb_pullup_off // Port B pull-ups removed
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic start; // Start bit as written
    logic busy; // Conversion running
    logic enable; // Converter powered
    logic justify; // Result format
    logic [2:0] chan; // External channel
    logic [2:0] src_sel; // Internal source
    logic [2:0] div_sel; // Clock divide select
    logic amp_en; // Amplifier enable
    logic bg_en; // Bandgap buffer enable
    logic [3:0] ref_sel; // Reference select
    logic [7:0] pins_a; // Port A analog selects
    logic [7:0] pins_b; // Port B analog selects
    adcc_result_type result; // Stored result bytes
    logic [7:0] rdata; // Read data register
    adcc_core_out_type core; // Core controls
    logic irq; // Interrupt pulse
    logic [7:0] pa_an; // Port A cut registers
    logic [7:0] pb_an; // Port B cut registers
  } adcc_state_type;
  adcc_state_type s_reg, s_next; // Block state
  adcc_route_type route_w; // Decoded routing
  logic tick_w; // Divider tick
  logic wr_c0; // Write to primary control
  logic new_start; // Start bit being written
  logic start_rise; // Start 0 to 1
  logic start_fall; // Start 1 to 0
  // ----------------------------------------
  // Sub blocks
  // ----------------------------------------
  // Routing priority decode
  adcc_route u_route (
    .chan(s_reg.chan),
    .src_sel(s_reg.src_sel),
    .ref_sel(s_reg.ref_sel),
    .route(route_w)
  );
  // Converter clock; runs only while enabled
  adcc_divider u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(s_reg.enable),
    .sel(s_reg.div_sel),
    .tick(tick_w)
  );
  // ----------------------------------------
  // Start edge detect
  // ----------------------------------------
  // Edges come from the written value, not from a pin
  always_comb begin
    wr_c0 = bus.wr && (bus.addr == `ADCC_OFF_CTRL0);
    new_start = bus.wdata[`ADCC_C0_START];
    start_rise = wr_c0 && !s_reg.start && new_start;
    start_fall = wr_c0 && s_reg.start && !new_start;
  end
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.core.reset = 1'b0; // Pulses last one cycle
    s_next.core.start = 1'b0;
    s_next.irq = 1'b0;
    s_next.rdata = `ADCC_RST_BYTE;
    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `ADCC_OFF_CTRL0: begin
          // Busy position is not taken from the bus
          s_next.start = bus.wdata[`ADCC_C0_START];
          s_next.enable = bus.wdata[`ADCC_C0_EN];
          s_next.justify = bus.wdata[`ADCC_C0_JUST];
          s_next.chan = bus.wdata[`ADCC_C0_CHAN_HI:`ADCC_C0_CHAN_LO];
        end
        `ADCC_OFF_CTRL1: begin
          s_next.src_sel = bus.wdata[`ADCC_C1_SRC_HI:`ADCC_C1_SRC_LO];
          s_next.div_sel = bus.wdata[`ADCC_C1_DIV_HI:`ADCC_C1_DIV_LO];
        end
        `ADCC_OFF_CTRL2: begin
          s_next.amp_en = bus.wdata[`ADCC_C2_AMP];
          s_next.bg_en = bus.wdata[`ADCC_C2_BG];
          s_next.ref_sel = bus.wdata[`ADCC_C2_REF_HI:`ADCC_C2_REF_LO];
        end
        `ADCC_OFF_PINS_A: s_next.pins_a = bus.wdata;
        `ADCC_OFF_PINS_B: s_next.pins_b = bus.wdata;
        default: begin
          // Result bytes and holes ignore writes
        end
      endcase
    end
    // Conversion sequencing; a rising start edge, or a falling one while enabled, outranks a done
    if (start_rise) begin
      s_next.busy = 1'b0;
      s_next.core.reset = 1'b1;
    end else if (start_fall && s_next.enable) begin
      s_next.busy = 1'b1;
      s_next.core.start = 1'b1;
    end else if (core_i.done && s_reg.busy) begin
      s_next.busy = 1'b0;
      s_next.irq = 1'b1;
      // Format as it stands now
      s_next.result = adcc_pack(s_reg.justify, core_i.data);
    end else if (!s_next.enable) begin
      // Powered down: no done will come, result kept
      s_next.busy = 1'b0;
    end
    // Register reads
    if (bus.rd) begin
      case (bus.addr)
        `ADCC_OFF_RES_HIGH: s_next.rdata = s_reg.result.high;
        `ADCC_OFF_RES_LOW: s_next.rdata = s_reg.result.low;
        `ADCC_OFF_CTRL0: begin
          // Busy reads back the live flag
          s_next.rdata = {s_reg.start, s_reg.busy, s_reg.enable, s_reg.justify,
                          1'b0, s_reg.chan};
        end
        `ADCC_OFF_CTRL1: s_next.rdata = {s_reg.src_sel, 2'h0, s_reg.div_sel};
        `ADCC_OFF_CTRL2: begin
          s_next.rdata = {s_reg.amp_en, s_reg.bg_en, 2'h0, s_reg.ref_sel};
        end
        `ADCC_OFF_PINS_A: s_next.rdata = s_reg.pins_a;
        `ADCC_OFF_PINS_B: s_next.rdata = s_reg.pins_b;
        default: s_next.rdata = `ADCC_RST_BYTE; // Unmapped reads zero
      endcase
    end
    // Core controls, registered so outputs come from flops
    s_next.core.enable = s_next.enable;
    s_next.core.tick = tick_w;
    s_next.core.route = route_w;
    s_next.core.amp_en = s_reg.amp_en;
    s_next.core.bg_en = s_reg.bg_en;
    // Analog pins drop I/O and pull-up
    s_next.pa_an = s_reg.pins_a;
    s_next.pb_an = s_reg.pins_b;
  end
  // ----------------------------------------
  // State register
  // ----------------------------------------
  // All control bits come up zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = s_reg.rdata;
  assign core_o = s_reg.core;
  assign conv_irq = s_reg.irq;
  assign pa_analog = s_reg.pa_an;
  assign pb_analog = s_reg.pb_an;
  // Same flops: a pull-up is never left on an analog pin
  assign pa_pullup_off = s_reg.pa_an;
  assign pb_pullup_off = s_reg.pb_an;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Rising start resets the core and clears busy
  property p_start_rise;
    @(posedge sys_clk) disable iff (rst)
      start_rise |=> (!s_reg.busy && core_o.reset && !core_o.start);
  endproperty
  a_start_rise: assert property (p_start_rise)
    else $error("start rise did not reset core");
  // Falling start while enabled launches a run
  property p_start_fall;
    @(posedge sys_clk) disable iff (rst)
      (start_fall && bus.wdata[`ADCC_C0_EN]) |=> (s_reg.busy && core_o.start);
  endproperty
  a_start_fall: assert property (p_start_fall)
    else $error("start fall did not launch");
  // Falling start while disabled launches nothing
  property p_no_launch;
    @(posedge sys_clk) disable iff (rst)
      (start_fall && !bus.wdata[`ADCC_C0_EN]) |=> (!core_o.start && !s_reg.busy);
  endproperty
  a_no_launch: assert property (p_no_launch)
    else $error("launch while disabled");
  // Done loads the result in the current format and pulses the request
  property p_done_load;
    @(posedge sys_clk) disable iff (rst)
      (core_i.done && s_reg.busy && !bus.wr) |=>
        (!s_reg.busy && conv_irq &&
         s_reg.result == adcc_pack($past(s_reg.justify), $past(core_i.data)));
  endproperty
  a_done_load: assert property (p_done_load)
    else $error("result not loaded at end");
  // Unused result bits are zero after a load
  property p_zero_bits;
    @(posedge sys_clk) disable iff (rst)
      conv_irq |-> ($past(s_reg.justify) ? (s_reg.result.high[7:4] == 4'h0)
                                         : (s_reg.result.low[3:0] == 4'h0));
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unused result bits set");
  // Disabling leaves the result untouched
  property p_keep_result;
    @(posedge sys_clk) disable iff (rst)
      (wr_c0 && !bus.wdata[`ADCC_C0_EN] && !core_i.done) |=> $stable(s_reg.result);
  endproperty
  a_keep_result: assert property (p_keep_result)
    else $error("result changed on disable");
  // High byte read returns the stored byte one cycle later
  property p_read_high;
    @(posedge sys_clk) disable iff (rst)
      (bus.rd && bus.addr == `ADCC_OFF_RES_HIGH) |=> (rdata == $past(s_reg.result.high));
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("result read wrong");
  // Amplifier codes route the amplifier two cycles after the write
  property p_amp_route;
    @(posedge sys_clk) disable iff (rst)
      (bus.wr && bus.addr == `ADCC_OFF_CTRL1 && bus.wdata[7] && bus.wdata[6:5] != 2'h0)
        |=> ##1 (core_o.route.src == ADCC_SRC_AMP);
  endproperty
  a_amp_route: assert property (p_amp_route)
    else $error("internal source not chosen");
  // Bandgap codes always pick the bandgap
  property p_bg_ref;
    @(posedge sys_clk) disable iff (rst)
      (s_reg.ref_sel inside {4'hA, 4'hB, 4'hC}) |=> (core_o.route.ref_src == ADCC_REF_BANDGAP);
  endproperty
  a_bg_ref: assert property (p_bg_ref)
    else $error("bandgap not chosen");
  // Analog pin select reaches both cut outputs
  property p_pins;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (pa_analog == $past(s_reg.pins_a) && pb_pullup_off == $past(s_reg.pins_b));
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin cut late");
endmodule

// [dv/adcc_top_tb.sv]
// Purpose: Self-checking bench for the converter control and result registers
// Assumes: Eight-channel variant; bench stands in for both the CPU and the analog core
// Notes: Register offsets come from the shared header; expectations are worked out here
`timescale 1ns/10ps
`include "adcc_regs.svh"
module adcc_top_tb import adcc_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk; // 20 MHz clock
  logic rst; // Sync reset, high
  adcc_bus_type bus; // Register port request
  logic [7:0] rdata; // Read data
  adcc_core_in_type core_i; // Done and data into the block
  adcc_core_out_type core_o; // Core controls out
  logic conv_irq; // End of conversion pulse
  logic [7:0] pa_analog, pb_analog, pa_pullup_off, pb_pullup_off; // Pin cut-offs
  int num_errors = 0; // Mismatches seen
  int check_count = 0; // Comparisons made
  int cycles = 0; // Cycle counter for the hang guard
  int ticks; // Tick count in the divider scenario

  adcc_top DUT (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .core_i(core_i),
    .core_o(core_o), .conv_irq(conv_irq), .pa_analog(pa_analog), .pb_analog(pb_analog),
    .pa_pullup_off(pa_pullup_off), .pb_pullup_off(pb_pullup_off)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run needs about 140 cycles; ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write; returns just after the edge that takes it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge sys_clk);
    bus.wr <= 1'h0;
    #1;
  endtask
  // One-cycle read; data sampled in the following cycle only
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus.rd <= 1'h1;
    bus.addr <= a;
    @(posedge sys_clk);
    bus.rd <= 1'h0;
    #1;
    chk(rdata, exp);
  endtask
  // Core reports a finished conversion; data turned over afterwards
  task automatic done(input logic [11:0] d);
    @(posedge sys_clk);
    core_i.done <= 1'h1;
    core_i.data <= d;
    @(posedge sys_clk);
    core_i.done <= 1'h0;
    core_i.data <= ~d;
    #1;
  endtask
  // Wait for a registered level to settle after a write
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every address reads zero after reset
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rchk(3'(a), 8'h00);
    end
    chk(pa_analog, 8'h00);
  endtask
  // Start edges, busy flag, both formats, late justify change
  task automatic t_convert();
    wr(`ADCC_OFF_CTRL0, 8'hFF);
    chk(core_o.reset, 1'h1);
    rchk(`ADCC_OFF_CTRL0, 8'hB7);
    wr(`ADCC_OFF_CTRL0, 8'h37);
    chk(core_o.start, 1'h1);
    rchk(`ADCC_OFF_CTRL0, 8'h77);
    done(12'hABC);
    chk(conv_irq, 1'h1);
    settle();
    chk(conv_irq, 1'h0);
    rchk(`ADCC_OFF_CTRL0, 8'h37);
    rchk(`ADCC_OFF_RES_HIGH, 8'h0A);
    rchk(`ADCC_OFF_RES_LOW, 8'hBC);
    // Justify flipped while busy: format taken at completion
    wr(`ADCC_OFF_CTRL0, 8'hB0);
    wr(`ADCC_OFF_CTRL0, 8'h30);
    wr(`ADCC_OFF_CTRL0, 8'h20);
    done(12'h5E3);
    rchk(`ADCC_OFF_RES_HIGH, 8'h5E);
    rchk(`ADCC_OFF_RES_LOW, 8'h30);
  endtask
  // Stray done, disable, result writes: stored value survives
  task automatic t_keep();
    done(12'hFFF);
    chk(conv_irq, 1'h0);
    wr(`ADCC_OFF_CTRL0, 8'h00);
    wr(`ADCC_OFF_RES_HIGH, 8'hFF);
    rchk(`ADCC_OFF_RES_HIGH, 8'h5E);
    rchk(`ADCC_OFF_RES_LOW, 8'h30);
    wr(3'h7, 8'hFF);
    rchk(3'h7, 8'h00);
  endtask
  // Start pulse while disabled launches nothing
  task automatic t_disabled();
    wr(`ADCC_OFF_CTRL0, 8'h80);
    wr(`ADCC_OFF_CTRL0, 8'h00);
    chk(core_o.start, 1'h0);
    rchk(`ADCC_OFF_CTRL0, 8'h00);
  endtask
  // Every internal source code against the pin choice
  task automatic t_source();
    adcc_src_type e;
    wr(`ADCC_OFF_CTRL0, 8'h05);
    for (int s = 0; s < 8; s++) begin
      e = (s == 0 || s == 4) ? ADCC_SRC_PIN : (s < 4) ? ADCC_SRC_SUPPLY : ADCC_SRC_AMP;
      wr(`ADCC_OFF_CTRL1, {3'(s), 5'h00});
      settle();
      chk(core_o.route.src, e);
      chk(core_o.route.chan, 3'h5);
      if (e != ADCC_SRC_PIN) begin
        chk(core_o.route.scale, 2'(s[1:0] - 1));
      end
    end
  endtask
  // Reference codes, bandgap winning over the pin
  task automatic t_ref();
    logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h4, 4'h9, 4'hA, 4'hC};
    adcc_ref_type exp[6] = '{ADCC_REF_SUPPLY, ADCC_REF_PIN, ADCC_REF_PIN,
      ADCC_REF_SUPPLY, ADCC_REF_BANDGAP, ADCC_REF_BANDGAP};
    logic [2:0] mult[6] = '{3'h1, 3'h1, 3'h4, 3'h1, 3'h2, 3'h4}; // Supply codes give one
    for (int i = 0; i < 6; i++) begin
      wr(`ADCC_OFF_CTRL2, {4'hC, codes[i]});
      settle();
      chk(core_o.route.ref_src, exp[i]);
      chk(core_o.route.ref_mult, mult[i]);
    end
    chk({core_o.amp_en, core_o.bg_en}, 2'h3);
  endtask
  // Converter clock divide by two
  task automatic t_divider();
    wr(`ADCC_OFF_CTRL1, 8'h01);
    wr(`ADCC_OFF_CTRL0, 8'h20);
    repeat (4) settle();
    ticks = 0;
    repeat (16) begin
      settle();
      ticks = ticks + int'(core_o.tick);
    end
    chk(16'(ticks), 16'h0008);
    chk(core_o.enable, 1'h1);
  endtask
  // Analog pins lose digital function and pull-up
  task automatic t_pins();
    wr(`ADCC_OFF_PINS_A, 8'h5A);
    wr(`ADCC_OFF_PINS_B, 8'hC3);
    settle();
    chk(pa_analog, 8'h5A);
    chk(pb_analog, 8'hC3);
    chk(pa_pullup_off, 8'h5A);
    chk(pb_pullup_off, 8'hC3);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    bus = '0;
    core_i = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset();
    t_convert();
    t_keep();
    t_disabled();
    t_source();
    t_ref();
    t_divider();
    t_pins();
    give_verdict();
  end
endmodule
